// [inc/lcdft_pkg.sv]
`default_nettype none
package lcdft_pkg;

  // Register indices; the byte address on APB is four times the index.
  localparam logic [9:0] IDX_FLAG       = 10'h00C;
  localparam logic [9:0] IDX_FLAG_EN    = 10'h08C;
  localparam logic [9:0] IDX_PRESCALE   = 10'h10E;
  localparam logic [9:0] IDX_CONTROL    = 10'h10F;
  localparam logic [9:0] IDX_PIXEL_BASE = 10'h110;
  localparam int         PIXEL_WORDS    = 16;

  // Field positions of display_control, the frame flag bit and the prescale width.
  localparam int CTL_DRIVE_EN   = 7;
  localparam int CTL_SLEEP_STOP = 6;
  localparam int CTL_WR_ERR     = 5;
  localparam int CTL_BIAS       = 4;
  localparam int CTL_SRC_LO     = 2;
  localparam int CTL_COM_LO     = 0;
  localparam int FLAG_FRAME_BIT = 7;
  localparam int PRESCALE_WIDTH = 4;

  // Values after reset.
  localparam logic [7:0] CONTROL_RST  = 8'h00;
  localparam logic [3:0] PRESCALE_RST = 4'h0;

  // Timing-source codes; both codes with the upper bit set pick the RC oscillator.
  localparam logic [1:0] SRC_SYS_DIV = 2'h0;
  localparam logic [1:0] SRC_AUX     = 2'h1;

  // Common-count code for three commons, the only mode with the short frame.
  localparam logic [1:0] COM_THREE = 2'h2;

  // Fixed divider on the system clock and frame lengths in prescaled ticks.
  localparam int         SYS_DIV           = 256;
  localparam logic [7:0] SYS_DIV_LAST      = 8'(SYS_DIV - 1);
  localparam int         FRAME_TICKS_STD   = 128;
  localparam int         FRAME_TICKS_THREE = 96;
  localparam logic [6:0] FRAME_LAST_STD    = 7'(FRAME_TICKS_STD - 1);
  localparam logic [6:0] FRAME_LAST_THREE  = 7'(FRAME_TICKS_THREE - 1);

  // Frame sequencer states.
  typedef enum logic [2:0] {
    ST_HALT  = 3'b001,
    ST_START = 3'b010,
    ST_RUN   = 3'b100
  } lcdft_state_t;

endpackage
`default_nettype wire

// [sim/lcdft_panel_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Panel side: it times each common phase and records which commons were driven.
module lcdft_panel_model
  import lcdft_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  commonDrive,
  output logic      [15:0] lastLen,
  output logic      [3:0]  seenMask
);
  logic [3:0]  prevCom;
  logic [15:0] cnt;

  // A length is only taken between two driven commons, so a partial phase at disable is never reported.
  always_ff @(posedge sys_clk) begin
    prevCom <= commonDrive;
    cnt     <= (commonDrive != prevCom) ? 16'h0001 : cnt + 16'h0001;
    if (rst || commonDrive == 4'h0) begin
      seenMask <= 4'h0;
    end else begin
      seenMask <= seenMask | commonDrive;
    end
    if (commonDrive != prevCom && prevCom != 4'h0 && commonDrive != 4'h0) begin
      lastLen <= cnt;
    end
  end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import lcdft_pkg::*;
;
  localparam logic [11:0] A_CTL = {IDX_CONTROL, 2'b00};
  localparam logic [11:0] A_PS  = {IDX_PRESCALE, 2'b00};
  localparam logic [11:0] A_FLG = {IDX_FLAG, 2'b00};
  localparam logic [11:0] A_FEN = {IDX_FLAG_EN, 2'b00};
  localparam logic [11:0] A_PIX = {IDX_PIXEL_BASE, 2'b00};

  logic        sys_clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cpuSleep;
  logic        auxClkIn;
  logic        rcClkIn;
  logic [3:0]  commonDrive;
  logic [31:0] segmentDrive;
  logic        minVoltageDrive;
  logic        biasPowerUp;
  logic        rcOscEnable;
  logic        frameIrq;
  logic [15:0] lastLen;
  logic [3:0]  seenMask;
  logic [1:0]  auxCnt;
  logic [2:0]  rcCnt;
  logic [31:0] rd;
  logic        se;
  int          err_count;
  int          compares;

  lcdft_frame_timing uut (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpuSleep(cpuSleep), .auxClkIn(auxClkIn), .rcClkIn(rcClkIn),
    .commonDrive(commonDrive), .segmentDrive(segmentDrive), .minVoltageDrive(minVoltageDrive),
    .biasPowerUp(biasPowerUp), .rcOscEnable(rcOscEnable), .frameIrq(frameIrq)
  );

  lcdft_panel_model panel (
    .sys_clk(sys_clk), .rst(rst), .commonDrive(commonDrive), .lastLen(lastLen), .seenMask(seenMask)
  );

  function automatic logic [7:0] ctl(input logic en, ss, bias, input logic [1:0] src, lm);
    return {en, ss, 1'b0, bias, src, lm};
  endfunction

  function automatic logic [7:0] pix(input int w);
    return 8'(w * 17) ^ 8'h5A;
  endfunction

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    int n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= 32'(d);
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    // Judge the timeout by the handshake itself, so an answer on the last try is not taken as a hang.
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, 32'(pready));
      close_out();
    end
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits, with a bound, until the given common is the driven one.
  task automatic waitc(input logic [3:0] v, input int lim);
    int n = 0;
    while (commonDrive !== v && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    if (commonDrive !== v) begin
      chk("common wait", 32'(v), 32'(commonDrive));
      close_out();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // The clock, with all inputs given a value at time zero.
  initial begin
    sys_clk  = 1'b0;
    rst      = 1'b1;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h000;
    pwdata   = 32'h0;
    cpuSleep = 1'b0;
    auxClkIn = 1'b0;
    rcClkIn  = 1'b0;
    auxCnt   = 2'h0;
    rcCnt    = 3'h0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Auxiliary ticks rise every 4 cycles and RC ticks every 6, so the sources give different lengths.
  always @(posedge sys_clk) begin
    auxCnt   <= auxCnt + 2'h1;
    rcCnt    <= (rcCnt == 3'h5) ? 3'h0 : rcCnt + 3'h1;
    auxClkIn <= auxCnt[1];
    rcClkIn  <= (rcCnt >= 3'h3);
  end

  // A hang is cut short well above the longest expected run.
  initial begin
    cyc(90000);
    chk("run length", 32'h0, 32'h1);
    close_out();
  end

  // Main sequence.
  initial begin
    int exp;
    cyc(5);
    rst <= 1'b0;
    @(posedge sys_clk);
    apb(A_CTL, 1'b0, 8'h00); chk("control reset", 32'(CONTROL_RST), rd);
    apb(A_PS, 1'b1, 8'hFF);
    apb(A_PS, 1'b0, 8'h00); chk("prescale upper bits", 32'h0000000F, rd);
    apb(12'h004, 1'b0, 8'h00); chk("unmapped refused", 32'h1, 32'(se));
    for (int w = 0; w < PIXEL_WORDS; w++) apb(12'(A_PIX + 4 * w), 1'b1, pix(w));
    apb(12'(A_PIX + 60), 1'b0, 8'h00); chk("pixel readback", 32'(pix(15)), rd);
    chk("idle commons", 32'h0, 32'(commonDrive));
    // Each common count, auxiliary source, prescale one: phase length and commons used, the static count only its one common.
    apb(A_PS, 1'b1, 8'h01);
    for (int m = 0; m < 4; m++) begin
      apb(A_CTL, 1'b1, ctl(1'b1, 1'b0, 1'b0, SRC_AUX, 2'(m)));
      waitc(4'h1, 4);
      if (m == 0) begin
        cyc(2000);
        chk("static common", 32'h1, 32'(commonDrive));
      end else begin
        waitc(4'h2, 2100);
        waitc(m == 1 ? 4'h1 : 4'h4, 2100);
        cyc(1);
        exp = (m == 2 ? FRAME_TICKS_THREE : FRAME_TICKS_STD) / (m + 1) * 2 * 4;
        chk("phase length", 32'(exp), 32'(lastLen));
        waitc(4'h1, 2100);
        cyc(1);
        chk("commons seen", 32'((1 << (m + 1)) - 1), 32'(seenMask));
      end
      apb(A_CTL, 1'b1, 8'h00);
      cyc(2);
      chk("commons off", 32'h0, 32'(commonDrive));
      chk("segments off", 32'h0, segmentDrive);
    end
    // Pixel bits reach the segments of their own common.
    apb(A_CTL, 1'b1, ctl(1'b1, 1'b0, 1'b1, SRC_AUX, 2'h3));
    cyc(2);
    chk("bias power", 32'h1, 32'(biasPowerUp));
    for (int c = 0; c < 4; c++) begin
      waitc(4'(1 << c), 2100);
      cyc(2);
      chk("segments", {pix(4*c+3), pix(4*c+2), pix(4*c+1), pix(4*c)}, segmentDrive);
    end
    // Frame event at the last phase, its mask, and the write window.
    apb(A_FEN, 1'b1, 8'h80);
    waitc(4'h1, 2100);
    apb(A_FLG, 1'b1, 8'h00);
    cyc(2);
    chk("event cleared", 32'h0, 32'(frameIrq));
    waitc(4'h8, 2100);
    cyc(2);
    chk("frame event", 32'h1, 32'(frameIrq));
    apb(A_FLG, 1'b0, 8'h00); chk("frame flag", 32'h80, rd);
    apb(A_PIX, 1'b1, pix(0));
    apb(A_CTL, 1'b0, 8'h00); chk("window write", 32'h97, rd);
    apb(A_FEN, 1'b1, 8'h00);
    cyc(2);
    chk("event masked", 32'h0, 32'(frameIrq));
    waitc(4'h1, 2100);
    apb(A_PIX, 1'b1, pix(0));
    cyc(800);
    apb(A_CTL, 1'b0, 8'h00); chk("write error sticky", 32'hB7, rd);
    apb(A_CTL, 1'b1, 8'h97);
    apb(A_CTL, 1'b0, 8'h00); chk("write error cleared", 32'h97, rd);
    // Sleep with and without sleep-stop.
    cpuSleep <= 1'b1;
    cyc(3);
    chk("drive in sleep", 32'h1, 32'(|commonDrive));
    chk("no min voltage", 32'h0, 32'(minVoltageDrive));
    apb(A_CTL, 1'b1, ctl(1'b1, 1'b1, 1'b0, SRC_AUX, 2'h3));
    cyc(2);
    chk("stop in sleep", 32'h0, 32'(commonDrive));
    chk("min voltage", 32'h1, 32'(minVoltageDrive));
    cpuSleep <= 1'b0;
    // Every source code, then an RC phase length at prescale zero.
    apb(A_PS, 1'b1, 8'h00);
    for (int s = 0; s < 4; s++) begin
      apb(A_CTL, 1'b1, ctl(1'b1, 1'b0, 1'b0, 2'(s), 2'h3));
      cyc(2);
      chk("rc enable", 32'(s >> 1), 32'(rcOscEnable));
    end
    waitc(4'h1, 2000);
    waitc(4'h2, 300);
    waitc(4'h4, 300);
    cyc(1);
    chk("rc phase", 32'(FRAME_TICKS_STD / 4 * 6), 32'(lastLen));
    apb(A_CTL, 1'b1, ctl(1'b0, 1'b0, 1'b0, 2'h2, 2'h3));
    cyc(2);
    chk("rc off", 32'h0, 32'(rcOscEnable));
    // System clock over the fixed divider.
    apb(A_CTL, 1'b1, ctl(1'b1, 1'b0, 1'b0, SRC_SYS_DIV, 2'h3));
    waitc(4'h1, 4);
    waitc(4'h2, 9000);
    waitc(4'h4, 9000);
    cyc(1);
    chk("sys phase", 32'(FRAME_TICKS_STD / 4 * SYS_DIV), 32'(lastLen));
    close_out();
  end
endmodule
`default_nettype wire

// [verilog/lcdft_frame_timing.sv]
// Chosen here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module lcdft_frame_timing
  import lcdft_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cpuSleep,
  input  wire logic        auxClkIn,
  input  wire logic        rcClkIn,
  output logic      [3:0]  commonDrive,
  output logic      [31:0] segmentDrive,
  output logic             minVoltageDrive,
  output logic             biasPowerUp,
  output logic             rcOscEnable,
  output logic             frameIrq
);

  typedef struct packed {
    lcdft_state_t st;
    logic [7:0]   ctl;
    logic [3:0]   prescale;
    logic         frameFlag;
    logic         frameEn;
    logic [127:0] pixels;
    logic [6:0]   cnt;
    logic [1:0]   phase;
    logic         auxPrev;
    logic         rcPrev;
    logic [3:0]   com;
    logic [31:0]  seg;
    logic         minV;
    logic         bias;
    logic         rcEn;
    logic         irq;
    logic [31:0]  rdata;
    logic         ready;
    logic         slverr;
  } lcdft_core_t;

  localparam lcdft_core_t CORE_RST = '{st: ST_HALT, ctl: CONTROL_RST, prescale: PRESCALE_RST, default: '0};

  lcdft_core_t s_reg;
  lcdft_core_t s_next;

  logic       tickSys;
  logic       baseTick;
  logic       selTick;
  logic       halted;
  logic [1:0] lmux;
  logic [6:0] frameLast;
  logic [6:0] nextCnt;
  logic       readPhase;
  logic [1:0] readIdx;
  logic       frameEvt;
  logic       disallowed;
  logic       setup;
  logic       access;
  logic [9:0] idx;
  logic [9:0] pixDiff;
  logic       pixHit;
  logic       mapped;
  logic       pixWrite;
  logic [7:0] rdMux;

  // Common phase that a frame count belongs to for the current mode.
  function automatic logic [1:0] phase_of(input logic [6:0] c, input logic [1:0] mode);
    logic [1:0] p;
    p = 2'h0;
    if (mode == 2'h1) begin
      p = {1'b0, c[6]};
    end else if (mode != 2'h0) begin
      p = c[6:5];
    end
    return p;
  endfunction

  // Fixed division of the system clock; no register reaches this divider.
  lcdft_tick_div #(
    .W (8)
  ) u_sys_div (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clear   (1'b0),
    .tickIn  (1'b1),
    .divLast (SYS_DIV_LAST),
    .tickOut (tickSys)
  );

  // Prescaler divides the selected timing clock by prescale plus one.
  lcdft_tick_div #(
    .W (PRESCALE_WIDTH)
  ) u_prescale (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clear   (s_reg.st != ST_RUN),
    .tickIn  (selTick),
    .divLast (s_reg.prescale),
    .tickOut (baseTick)
  );

  // Address decode for the APB slave; only word-aligned hits are mapped.
  always_comb begin
    idx     = paddr[11:2];
    pixDiff = idx - IDX_PIXEL_BASE;
    pixHit  = (idx >= IDX_PIXEL_BASE) && (pixDiff < 10'(PIXEL_WORDS));
    mapped  = (paddr[1:0] == 2'h0) &&
              (pixHit || idx == IDX_FLAG || idx == IDX_FLAG_EN || idx == IDX_PRESCALE || idx == IDX_CONTROL);
    setup   = psel && !penable;
    access  = psel && penable && s_reg.ready;
  end

  // Read data is chosen in the setup cycle so prdata leaves a flip-flop.
  always_comb begin
    rdMux = 8'h00;
    if (pixHit) begin
      rdMux = s_reg.pixels[{pixDiff[3:0], 3'h0} +: 8];
    end else if (idx == IDX_CONTROL) begin
      rdMux = s_reg.ctl;
    end else if (idx == IDX_PRESCALE) begin
      rdMux = {4'h0, s_reg.prescale};
    end else if (idx == IDX_FLAG) begin
      rdMux = {s_reg.frameFlag, 7'h00};
    end else if (idx == IDX_FLAG_EN) begin
      rdMux = {s_reg.frameEn, 7'h00};
    end
  end

  // Timing-source selection; the edge detectors see inputs that are already synchronous.
  always_comb begin
    halted = !s_reg.ctl[CTL_DRIVE_EN] || (cpuSleep && s_reg.ctl[CTL_SLEEP_STOP]);
    lmux   = s_reg.ctl[CTL_COM_LO +: 2];
    unique case (s_reg.ctl[CTL_SRC_LO +: 2])
      SRC_SYS_DIV: selTick = tickSys;
      SRC_AUX:     selTick = auxClkIn && !s_reg.auxPrev;
      default:     selTick = rcClkIn && !s_reg.rcPrev;
    endcase
    frameLast = (lmux == COM_THREE) ? FRAME_LAST_THREE : FRAME_LAST_STD;
    nextCnt   = (s_reg.cnt == frameLast) ? 7'h00 : s_reg.cnt + 7'h01;
  end

  // Frame sequencer, pixel reads and register updates.
  always_comb begin
    s_next         = s_reg;
    readPhase      = 1'b0;
    readIdx        = 2'h0;
    frameEvt       = 1'b0;
    pixWrite       = 1'b0;
    s_next.auxPrev = auxClkIn;
    s_next.rcPrev  = rcClkIn;

    unique case (s_reg.st)
      ST_HALT: begin
        s_next.cnt   = 7'h00;
        s_next.phase = 2'h0;
        if (!halted) begin
          s_next.st = ST_START;
        end
      end
      ST_START: begin
        if (halted) begin
          s_next.st = ST_HALT;
        end else begin
          readPhase = 1'b1;
          s_next.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (halted) begin
          s_next.st = ST_HALT;
        end else if (baseTick) begin
          s_next.cnt = nextCnt;
          if (nextCnt == 7'h00 || phase_of(nextCnt, lmux) != s_reg.phase) begin
            readPhase = 1'b1;
            readIdx   = phase_of(nextCnt, lmux);
          end
        end
      end
    endcase

    // A phase start loads the next common's segment row; the last row raises the frame event.
    if (readPhase) begin
      s_next.phase = readIdx;
      s_next.com   = 4'h1 << readIdx;
      s_next.seg   = s_reg.pixels[{readIdx, 5'h00} +: 32];
      frameEvt     = (readIdx == lmux);
    end
    // Stopped driving forces every line to the minimum level at once.
    if (halted) begin
      s_next.com = 4'h0;
      s_next.seg = 32'h0;
    end
    s_next.minV = cpuSleep && s_reg.ctl[CTL_SLEEP_STOP] && s_reg.ctl[CTL_DRIVE_EN];
    s_next.bias = s_reg.ctl[CTL_BIAS];
    s_next.rcEn = s_reg.ctl[CTL_DRIVE_EN] && s_reg.ctl[CTL_SRC_LO + 1];
    s_next.irq  = s_reg.frameFlag && s_reg.frameEn;

    // APB answers with one access cycle and no wait states.
    s_next.ready = setup;
    if (setup) begin
      s_next.rdata  = {24'h000000, rdMux};
      s_next.slverr = !mapped;
    end
    if (access && pwrite && pstrb[0] && !s_reg.slverr) begin
      if (pixHit) begin
        s_next.pixels[{pixDiff[3:0], 3'h0} +: 8] = pwdata[7:0];
        pixWrite = 1'b1;
      end else if (idx == IDX_CONTROL) begin
        s_next.ctl = pwdata[7:0];
      end else if (idx == IDX_PRESCALE) begin
        s_next.prescale = pwdata[PRESCALE_WIDTH-1:0];
      end else if (idx == IDX_FLAG) begin
        s_next.frameFlag = pwdata[FLAG_FRAME_BIT];
      end else if (idx == IDX_FLAG_EN) begin
        s_next.frameEn = pwdata[FLAG_FRAME_BIT];
      end
    end

    // Hardware sets come last so an event in the clearing cycle is not lost.
    if (frameEvt) begin
      s_next.frameFlag = 1'b1;
    end
    if (pixWrite && disallowed) begin
      s_next.ctl[CTL_WR_ERR] = 1'b1;
    end
  end

  // Writes are safe while halted or in the last common phase, between the frame event and the boundary.
  assign disallowed = (s_reg.st != ST_HALT) && !((s_reg.st == ST_RUN) && (s_reg.phase == lmux));

  // All state registers together; reset is synchronous.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_reg <= CORE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata          = s_reg.rdata;
  assign pready          = s_reg.ready;
  assign pslverr         = s_reg.slverr;
  assign commonDrive     = s_reg.com;
  assign segmentDrive    = s_reg.seg;
  assign minVoltageDrive = s_reg.minV;
  assign biasPowerUp     = s_reg.bias;
  assign rcOscEnable     = s_reg.rcEn;
  assign frameIrq        = s_reg.irq;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_ctl_write;
    access && pwrite && pstrb[0] && idx == IDX_CONTROL;
  endsequence

  sequence s_frame_start;
    readPhase && readIdx == 2'h0;
  endsequence

  property p_drive_off;
    !s_reg.ctl[CTL_DRIVE_EN] |=> (commonDrive == 4'h0 && segmentDrive == 32'h0);
  endproperty
  a_drive_off: assert property (p_drive_off) else $error("panel driven while drive is disabled");

  property p_sleep_keep;
    (s_reg.st == ST_RUN && s_reg.ctl[CTL_DRIVE_EN] && !s_reg.ctl[CTL_SLEEP_STOP]) |=> s_reg.st == ST_RUN;
  endproperty
  a_sleep_keep: assert property (p_sleep_keep) else $error("driving stopped although sleep-stop is clear");

  property p_sleep_stop;
    (cpuSleep && s_reg.ctl[CTL_SLEEP_STOP] && s_reg.ctl[CTL_DRIVE_EN]) |=> (minVoltageDrive && commonDrive == 4'h0);
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("sleep with sleep-stop did not halt the display");

  property p_wr_err;
    (pixWrite && disallowed) |=> s_reg.ctl[CTL_WR_ERR];
  endproperty
  a_wr_err: assert property (p_wr_err) else $error("disallowed pixel write not flagged");

  property p_bias;
    (s_ctl_write and !s_reg.slverr) |-> ##2 biasPowerUp == $past(pwdata[CTL_BIAS], 2);
  endproperty
  a_bias: assert property (p_bias) else $error("bias output does not follow the written bit");

  property p_rc_off;
    (!s_reg.ctl[CTL_DRIVE_EN] || !s_reg.ctl[CTL_SRC_LO + 1]) |=> !rcOscEnable;
  endproperty
  a_rc_off: assert property (p_rc_off) else $error("RC oscillator left powered");

  property p_frame_start;
    s_frame_start |=> (commonDrive == 4'h1 && s_reg.cnt == 7'h00);
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame did not start on the first common");

  property p_frame_wrap;
    (s_reg.st == ST_RUN) |-> s_reg.cnt <= frameLast;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) else $error("frame counter passed the frame length");

  property p_frame_evt;
    (frameEvt && s_reg.frameEn && !halted) |=> s_reg.frameFlag ##1 frameIrq;
  endproperty
  a_frame_evt: assert property (p_frame_evt) else $error("frame event did not reach the interrupt");

  property p_prescale_read;
    (setup && idx == IDX_PRESCALE && paddr[1:0] == 2'h0) |=> (pready && prdata[31:4] == 28'h0 && !pslverr);
  endproperty
  a_prescale_read: assert property (p_prescale_read) else $error("prescale upper bits not zero");

endmodule
`default_nettype wire

// [verilog/lcdft_tick_div.sv]
`timescale 1ns/100ps
`default_nettype none
// Divides a stream of one-cycle ticks by (divLast + 1) and emits one-cycle pulses.
module lcdft_tick_div
  import lcdft_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         clear,
  input  wire logic         tickIn,
  input  wire logic [W-1:0] divLast,
  output logic              tickOut
);

  generate
    if (W < 1) begin : g_bad_width
      $error("lcdft_tick_div needs a width of at least one bit");
    end
  endgenerate

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         out;
  } lcdft_div_t;

  lcdft_div_t s_reg;
  lcdft_div_t s_next;

  // The count restarts whenever clear is high so a new frame starts from a full period.
  always_comb begin
    s_next     = s_reg;
    s_next.out = 1'b0;
    if (clear) begin
      s_next.cnt = '0;
    end else if (tickIn) begin
      if (s_reg.cnt >= divLast) begin
        s_next.cnt = '0;
        s_next.out = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + W'(1);
      end
    end
  end

  // Synchronous reset to a cleared counter.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tickOut = s_reg.out;

endmodule
`default_nettype wire
